/* rtl/com_output_map.sv */
// top: AHB-Lite register bank decoding the cyclic output image, plus front-panel menu entry
//
// Implementation choice: the AHB-Lite slave port.
module com_output_map
	import com_pkg::*;
#(
	parameter int TICK_CYC = TICK_CYCLES
)
(
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic [31:0]                 hrdata,
	input  wire logic                   valvePolarityNo,
	input  wire logic                   setBtnN,
	input  wire logic                   upBtnN,
	input  wire logic                   downBtnN,
	output logic                        standbyReq,
	output logic                        forcedStandbyReq,
	output logic                        proportionalRegulatorOn,
	output logic                        supplyValveOn,
	output logic                        port4DigitalOut,
	output logic [PD_BYTES*8-1:0]       port4ProcessData,
	output logic                        menuActive,
	output logic [FIDX_W-1:0]           functionIndex
);

	// ==========================================================================
	// bus address phase capture
	// ==========================================================================
	logic                   addrPhase;
	logic [IDX_W-1:0]       addrIdx;
	logic                   wrPend_reg;
	logic [IDX_W-1:0]       wrIdx_reg;

	assign addrPhase = hsel & hready & (htrans == HTRANS_NONSEQ);
	assign addrIdx   = haddr[ADDR_LSB +: IDX_W];

	// hsize is not checked: only whole-word single transfers are issued
	always_ff @(posedge clk) begin
		if (srst) begin
			wrPend_reg <= 1'b0;
			wrIdx_reg  <= '0;
		end else begin
			wrPend_reg <= addrPhase & hwrite;
			wrIdx_reg  <= addrIdx;
		end
	end

	// ==========================================================================
	// write decode
	// ==========================================================================
	logic                   upperZero;
	logic                   wrCtrl;
	logic                   wrPort4;
	logic                   wrPd;
	logic                   wrSet;
	logic [IDX_W-1:0]       pdOff;
	logic [IDX_W-1:0]       setOff;
	logic [7:0]             wByte;

	assign upperZero = (haddr[31:ADDR_LSB+IDX_W] == '0);
	assign wByte     = hwdata[7:0];
	assign wrCtrl    = wrPend_reg & (wrIdx_reg == IDX_CONTROL);
	assign wrPort4   = wrPend_reg & (wrIdx_reg == IDX_PORT_FOUR);
	assign wrPd      = wrPend_reg & (wrIdx_reg >= IDX_PD_FIRST) & (wrIdx_reg <= IDX_PD_LAST);
	assign pdOff     = wrIdx_reg - IDX_PD_FIRST;
	assign setOff    = wrIdx_reg - IDX_SETTING_BASE;
	assign wrSet     = wrPend_reg & (wrIdx_reg >= IDX_SETTING_BASE)
	                 & (setOff < IDX_W'(NUM_FUNC));

	// ==========================================================================
	// output bytes 0 and 1
	// ==========================================================================
	logic [CTRL_USED_W-1:0] ctrl_reg;
	logic                   p4Dout_reg;

	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_reg   <= '0;
			p4Dout_reg <= 1'b0;
		end else begin
			if (wrCtrl)
				ctrl_reg <= wByte[CTRL_USED_W-1:0];
			if (wrPort4)
				p4Dout_reg <= wByte[BIT_P4_DOUT];
		end
	end

	// ==========================================================================
	// request outputs and isolation valves
	// ==========================================================================
	logic polA_reg;
	logic polB_reg;
	logic regNext;
	logic valveNext;

	// nc: bit 2 drives both; no: bit 3 selects exhaust (valve on) or supply
	assign regNext   = polB_reg ? ~ctrl_reg[BIT_ISO_NO] : ctrl_reg[BIT_ISO_NC];
	assign valveNext = polB_reg ?  ctrl_reg[BIT_ISO_NO] : ctrl_reg[BIT_ISO_NC];

	always_ff @(posedge clk) begin
		if (srst) begin
			polA_reg                <= 1'b0;
			polB_reg                <= 1'b0;
			standbyReq              <= 1'b0;
			forcedStandbyReq        <= 1'b0;
			proportionalRegulatorOn <= 1'b0;
			supplyValveOn           <= 1'b0;
			port4DigitalOut         <= 1'b0;
		end else begin
			polA_reg                <= valvePolarityNo;
			polB_reg                <= polA_reg;
			standbyReq              <= ctrl_reg[BIT_STANDBY];
			forcedStandbyReq        <= ctrl_reg[BIT_FORCED];
			proportionalRegulatorOn <= regNext;
			supplyValveOn           <= valveNext;
			port4DigitalOut         <= p4Dout_reg;
		end
	end

	// ==========================================================================
	// process data and function settings, one register per entry
	// ==========================================================================
	logic [PD_BYTES-1:0][7:0] pd_reg;
	logic [7:0]               setting_reg [NUM_FUNC];

	genvar g;
	generate
		for (g = 0; g < PD_BYTES; g++) begin : gPd
			always_ff @(posedge clk) begin
				if (srst)
					pd_reg[g] <= BYTE_RESET;
				else if (wrPd && pdOff == IDX_W'(g))
					pd_reg[g] <= wByte;
			end
		end
		for (g = 0; g < NUM_FUNC; g++) begin : gSet
			always_ff @(posedge clk) begin
				if (srst)
					setting_reg[g] <= BYTE_RESET;
				else if (wrSet && setOff == IDX_W'(g))
					setting_reg[g] <= wByte;
			end
		end
	endgenerate

	assign port4ProcessData = pd_reg;

	// ==========================================================================
	// millisecond tick and buttons
	// ==========================================================================
	logic [31:0]       tickCnt_reg;
	logic              tick_reg;
	logic              setLong;
	logic              upPress;
	logic              downPress;
	logic [HOLD_W-1:0] setLimit;
	com_mode_t         mode_reg;

	always_ff @(posedge clk) begin
		if (srst || tick_reg) begin
			tickCnt_reg <= '0;
			tick_reg    <= 1'b0;
		end else begin
			tickCnt_reg <= tickCnt_reg + 1'b1;
			tick_reg    <= (tickCnt_reg == 32'(TICK_CYC - 2));
		end
	end

	// the hold already counted past the entry time cannot also trigger exit
	assign setLimit = (mode_reg == MODE_MEASURE) ? SET_ENTER_TICKS : SET_EXIT_TICKS;

	com_button uSet (
		.clk        (clk),
		.srst       (srst),
		.tick       (tick_reg),
		.btnRawN    (setBtnN),
		.holdLimit  (setLimit),
		.pressPulse (),
		.longPulse  (setLong)
	);

	com_button uUp (
		.clk        (clk),
		.srst       (srst),
		.tick       (tick_reg),
		.btnRawN    (upBtnN),
		.holdLimit  ('1),
		.pressPulse (upPress),
		.longPulse  ()
	);

	com_button uDown (
		.clk        (clk),
		.srst       (srst),
		.tick       (tick_reg),
		.btnRawN    (downBtnN),
		.holdLimit  ('1),
		.pressPulse (downPress),
		.longPulse  ()
	);

	// ==========================================================================
	// menu state machine
	// ==========================================================================
	logic [FIDX_W-1:0] fidxUp;
	logic [FIDX_W-1:0] fidxDown;

	assign fidxUp   = (functionIndex == FIDX_LAST)  ? FIDX_FIRST : functionIndex + 1'b1;
	assign fidxDown = (functionIndex == FIDX_FIRST) ? FIDX_LAST  : functionIndex - 1'b1;

	always_ff @(posedge clk) begin
		if (srst) begin
			mode_reg      <= MODE_MEASURE;
			menuActive    <= 1'b0;
			functionIndex <= FIDX_FIRST;
		end else begin
			unique case (mode_reg)
				MODE_MEASURE: begin
					if (setLong) begin
						mode_reg      <= MODE_SELECT;
						menuActive    <= 1'b1;
						functionIndex <= FIDX_FIRST;
					end
				end
				MODE_SELECT: begin
					if (setLong) begin
						mode_reg   <= MODE_MEASURE;
						menuActive <= 1'b0;
					end else if (upPress && !downPress)
						functionIndex <= fidxUp;
					else if (downPress && !upPress)
						functionIndex <= fidxDown;
				end
			endcase
		end
	end

	// ==========================================================================
	// read path: data registered in the address phase, zero wait states
	// ==========================================================================
	logic [IDX_W-1:0] rdSetOff;
	logic             rdSetHit;
	logic [7:0]       rdSetVal;
	logic [31:0]      rdMux;

	assign rdSetOff = addrIdx - IDX_SETTING_BASE;
	assign rdSetHit = (addrIdx >= IDX_SETTING_BASE) & (rdSetOff < IDX_W'(NUM_FUNC));
	// forward a write still in its data phase so back-to-back read sees it
	assign rdSetVal = (wrSet && setOff == rdSetOff) ? wByte
	                : setting_reg[rdSetOff[FIDX_W-1:0]];
	assign rdMux    = !upperZero                ? 32'h0000_0000
	                : (addrIdx == IDX_STATUS)   ? {16'h0000, 1'b0, FUNC_CODE[functionIndex],
	                                               3'b000, functionIndex, menuActive}
	                : rdSetHit                  ? {24'h00_0000, rdSetVal}
	                :                             32'h0000_0000;

	always_ff @(posedge clk) begin
		if (srst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b0;
			hresp     <= HRESP_OKAY;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= HRESP_OKAY;
			if (addrPhase && !hwrite)
				hrdata <= rdMux;
		end
	end

	// ==========================================================================
	// checks
	// ==========================================================================
	a_standby_write: assert property (@(posedge clk) disable iff (srst)
		wrCtrl |=> ##1 standbyReq == $past(wByte[BIT_STANDBY], 2))
		else $error("standby request does not follow byte 0 bit 0");

	a_forced_write: assert property (@(posedge clk) disable iff (srst)
		wrCtrl |=> ##1 forcedStandbyReq == $past(wByte[BIT_FORCED], 2))
		else $error("forced standby does not follow byte 0 bit 1");

	a_nc_isolation: assert property (@(posedge clk) disable iff (srst)
		!polB_reg |=> proportionalRegulatorOn == $past(ctrl_reg[BIT_ISO_NC])
		           && supplyValveOn == $past(ctrl_reg[BIT_ISO_NC]))
		else $error("nc isolation outputs wrong");

	a_no_isolation: assert property (@(posedge clk) disable iff (srst)
		polB_reg |=> proportionalRegulatorOn != supplyValveOn
		          && supplyValveOn == $past(ctrl_reg[BIT_ISO_NO]))
		else $error("no isolation outputs wrong");

	a_port4_dout: assert property (@(posedge clk) disable iff (srst)
		wrPort4 |=> ##1 port4DigitalOut == $past(wByte[BIT_P4_DOUT], 2))
		else $error("port 4 digital output does not follow byte 1 bit 6");

	a_pd_passthru: assert property (@(posedge clk) disable iff (srst)
		wrPd && pdOff == '0 |=> port4ProcessData[7:0] == $past(wByte))
		else $error("first process data byte not forwarded");

	a_menu_enter: assert property (@(posedge clk) disable iff (srst)
		mode_reg == MODE_MEASURE && setLong |=> menuActive && functionIndex == FIDX_FIRST)
		else $error("long set press did not enter selection");

	a_menu_step: assert property (@(posedge clk) disable iff (srst)
		mode_reg == MODE_SELECT && !setLong && upPress && !downPress
		|=> functionIndex != $past(functionIndex))
		else $error("up press did not step the function");

	a_menu_exit: assert property (@(posedge clk) disable iff (srst)
		mode_reg == MODE_SELECT && setLong |=> !menuActive ##1 !menuActive)
		else $error("long set press did not leave selection");

	a_setting_isolated: assert property (@(posedge clk) disable iff (srst)
		!(wrSet && setOff == '0) |=> $stable(setting_reg[0]))
		else $error("setting 0 changed by another write");

	a_reserved_ignored: assert property (@(posedge clk) disable iff (srst)
		wrCtrl |=> ctrl_reg == $past(wByte[CTRL_USED_W-1:0]))
		else $error("control byte store wrong");

endmodule : com_output_map

/* pkg/com_pkg.sv */
// package: register map, output-byte fields, menu constants and timing for the output map block
package com_pkg;

	// ==========================================================================
	// register indices (byte address = 4 * index)
	// ==========================================================================
	localparam int          IDX_W            = 6;
	localparam logic [5:0]  IDX_CONTROL      = 6'h00;
	localparam logic [5:0]  IDX_PORT_FOUR    = 6'h01;
	localparam logic [5:0]  IDX_PD_FIRST     = 6'h02;
	localparam logic [5:0]  IDX_PD_LAST      = 6'h11;
	localparam logic [5:0]  IDX_STATUS       = 6'h18;
	localparam logic [5:0]  IDX_SETTING_BASE = 6'h20;
	localparam int          ADDR_LSB         = 2;

	// ==========================================================================
	// output byte 0 and byte 1 fields
	// ==========================================================================
	localparam int          BIT_STANDBY      = 0;
	localparam int          BIT_FORCED       = 1;
	localparam int          BIT_ISO_NC       = 2;
	localparam int          BIT_ISO_NO       = 3;
	localparam int          CTRL_USED_W      = 4;
	localparam int          BIT_P4_DOUT      = 6;
	localparam int          PD_BYTES         = 16;
	localparam logic [7:0]  BYTE_RESET       = 8'h00;

	// ==========================================================================
	// function selection menu
	// ==========================================================================
	localparam int          NUM_FUNC         = 15;
	localparam int          FIDX_W           = 4;
	localparam logic [3:0]  FIDX_FIRST       = 4'h0;
	localparam logic [3:0]  FIDX_LAST        = 4'he;
	// displayed function numbers, first entry shown on entry
	localparam logic [NUM_FUNC-1:0][6:0] FUNC_CODE = {
		7'h63, 7'h62, 7'h60, 7'h5a, 7'h51, 7'h50, 7'h29, 7'h28,
		7'h1e, 7'h10, 7'h0e, 7'h0d, 7'h06, 7'h03, 7'h00};

	typedef enum logic {MODE_MEASURE, MODE_SELECT} com_mode_t;

	// ==========================================================================
	// timing
	// ==========================================================================
	localparam int          CLK_PERIOD_NS    = 4;
	localparam int          TICK_NS          = 1000000;
	localparam int          TICK_CYCLES      = TICK_NS / CLK_PERIOD_NS;
	localparam int          TICKS_PER_S      = 1000;
	localparam int          SET_ENTER_S      = 3;
	localparam int          SET_EXIT_S       = 2;
	localparam int          HOLD_W           = 16;
	localparam logic [15:0] SET_ENTER_TICKS  = 16'(SET_ENTER_S * TICKS_PER_S);
	localparam logic [15:0] SET_EXIT_TICKS   = 16'(SET_EXIT_S * TICKS_PER_S);

	// AHB-Lite
	localparam logic [1:0]  HTRANS_NONSEQ    = 2'b10;
	localparam logic        HRESP_OKAY       = 1'b0;

endpackage : com_pkg

/* rtl/com_button.sv */
// front-panel button: pin synchroniser, press edge and once-per-hold long-press detector
module com_button
	import com_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic              tick,
	input  wire logic              btnRawN,
	input  wire logic [HOLD_W-1:0] holdLimit,
	output logic                   pressPulse,
	output logic                   longPulse
);

	// ==========================================================================
	// synchroniser and edge
	// ==========================================================================
	logic              syncA_reg;
	logic              syncB_reg;
	logic              prev_reg;
	logic [HOLD_W-1:0] hold_reg;
	logic              fired_reg;
	logic              held;
	logic              reach;

	assign held  = ~syncB_reg;
	assign reach = held & ~fired_reg & (hold_reg >= holdLimit);

	always_ff @(posedge clk) begin
		if (srst) begin
			syncA_reg <= 1'b1;
			syncB_reg <= 1'b1;
			prev_reg  <= 1'b0;
		end else begin
			syncA_reg <= btnRawN;
			syncB_reg <= syncA_reg;
			prev_reg  <= held;
		end
	end

	// ==========================================================================
	// hold counter; fires once, so a long hold cannot re-trigger
	// ==========================================================================
	always_ff @(posedge clk) begin
		if (srst || !held) begin
			hold_reg  <= '0;
			fired_reg <= 1'b0;
		end else begin
			if (tick && hold_reg != '1)
				hold_reg <= hold_reg + 1'b1;
			if (reach)
				fired_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pressPulse <= 1'b0;
			longPulse  <= 1'b0;
		end else begin
			pressPulse <= held & ~prev_reg;
			longPulse  <= reach;
		end
	end

endmodule : com_button

/* dv/com_fieldbus_master.sv */
// fieldbus controller model: single-word AHB-Lite writes and reads of the output image
module com_fieldbus_master
	import com_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// ==========================================================================
	// one transfer: address phase, then data phase, each held until hready
	// ==========================================================================
	task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'b00};
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		hsize <= 3'b010;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		// released lines never keep the old value, so a stale sample shows up
		haddr <= ~haddr;
		hwdata <= wr ? d : ~hwdata;
		do @(posedge clk); while (hready !== 1'b1);
		q = hrdata;
		hwdata <= ~hwdata;
	endtask : xfer

	// cyclic control byte as a well-behaved controller sends it
	task automatic ctrl(input logic [7:0] b);
		logic [31:0] q;
		xfer(1'b1, IDX_CONTROL, {24'h0, b & 8'h0f}, q);
	endtask : ctrl
endmodule : com_fieldbus_master

/* dv/tb_top.sv */
// testbench: output image decode, process data, settings bytes and menu entry
module tb_top
	import com_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// 1 ms tick shortened to 4 cycles so 3 s is 12000 cycles
	localparam int TC   = 4;
	localparam int CEIL = 60000;

	logic         clk, srst, hsel, hwrite, hreadyout, hresp;
	logic [31:0]  haddr, hwdata, hrdata, q;
	logic [1:0]   htrans;
	logic [2:0]   hsize;
	logic         valvePolarityNo, setBtnN, upBtnN, downBtnN;
	logic         standbyReq, forcedStandbyReq, proportionalRegulatorOn, supplyValveOn;
	logic         port4DigitalOut, menuActive;
	logic [127:0] port4ProcessData, pd;
	logic [3:0]   functionIndex;
	int           p, v, k, cyc, nFail, totalChecks;
	logic [6:0]   fn [15] = '{7'h00, 7'h03, 7'h06, 7'h0d, 7'h0e, 7'h10, 7'h1e, 7'h28,
		7'h29, 7'h50, 7'h51, 7'h5a, 7'h60, 7'h62, 7'h63};

	com_output_map #(.TICK_CYC(TC)) dut (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.valvePolarityNo(valvePolarityNo), .setBtnN(setBtnN), .upBtnN(upBtnN),
		.downBtnN(downBtnN), .standbyReq(standbyReq), .forcedStandbyReq(forcedStandbyReq),
		.proportionalRegulatorOn(proportionalRegulatorOn), .supplyValveOn(supplyValveOn),
		.port4DigitalOut(port4DigitalOut), .port4ProcessData(port4ProcessData),
		.menuActive(menuActive), .functionIndex(functionIndex));

	com_fieldbus_master master (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// ==========================================================================
	// shared tasks
	// ==========================================================================
	task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string m);
		totalChecks++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [5:0] i, input logic [31:0] d);
		logic [31:0] r;
		master.xfer(1'b1, i, d, r);
	endtask : wr

	task automatic rd(input logic [5:0] i, output logic [31:0] r);
		master.xfer(1'b0, i, 32'h0, r);
	endtask : rd

	task automatic hold(input int n);
		setBtnN <= 1'b0;
		repeat (n) @(posedge clk);
		setBtnN <= 1'b1;
		repeat (12) @(posedge clk);
	endtask : hold

	task automatic press(input logic u, input logic d);
		@(posedge clk);
		upBtnN <= !u;
		downBtnN <= !d;
		repeat (4) @(posedge clk);
		upBtnN <= 1'b1;
		downBtnN <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : press

	task automatic stat(input int i);
		logic [31:0] r;
		rd(IDX_STATUS, r);
		chk({r[14:8], r[4:0]}, {fn[i], 4'(i), 1'b1}, "status");
	endtask : stat

	task automatic tdone(input string s);
		$display("test %s done, checks %0d", s, totalChecks);
	endtask : tdone

	task automatic results();
		$display("checks %0d mismatches %0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == CEIL) begin
			nFail++;
			$display("MISMATCH t=%0t run did not finish", $time);
			results();
		end
	end

	// ==========================================================================
	// main sequence
	// ==========================================================================
	initial begin
		srst = 1'b1;
		valvePolarityNo = 1'b0;
		setBtnN = 1'b1;
		upBtnN = 1'b1;
		downBtnN = 1'b1;
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		repeat (2) @(posedge clk);
		chk({hreadyout, hresp, standbyReq, menuActive}, 4'b1000, "after reset");
		tdone("reset");
		// reserved upper nibble nonzero for every v except 3, to show it is ignored
		for (p = 0; p < 2; p++) begin
			valvePolarityNo <= p[0];
			for (v = 0; v < 16; v++) begin
				wr(IDX_CONTROL, {24'h0, 4'(v * 5 + 1), 4'(v)});
				repeat (4) @(posedge clk);
				chk(standbyReq, v[0], "standby");
				chk(forcedStandbyReq, v[1], "forced standby");
				if (p == 0) chk({proportionalRegulatorOn, supplyValveOn}, {v[2], v[2]}, "nc");
				else chk({proportionalRegulatorOn, supplyValveOn}, {~v[3], v[3]}, "no");
			end
		end
		master.ctrl(8'hf3);
		repeat (4) @(posedge clk);
		chk({standbyReq, forcedStandbyReq}, 2'b11, "clean control");
		rd(IDX_CONTROL, q);
		chk(q, 32'h0, "write-only control");
		tdone("control");
		wr(IDX_PORT_FOUR, 32'hbf);
		repeat (4) @(posedge clk);
		chk(port4DigitalOut, 1'b0, "dout low");
		wr(IDX_PORT_FOUR, 32'h40);
		repeat (4) @(posedge clk);
		chk(port4DigitalOut, 1'b1, "dout high");
		for (k = 0; k < PD_BYTES; k++) begin
			pd[8 * k +: 8] = 8'(k * 17 + 3);
			wr(6'(IDX_PD_FIRST + k), {24'h0, pd[8 * k +: 8]});
		end
		repeat (4) @(posedge clk);
		chk(port4ProcessData, pd, "process data");
		wr(6'h3f, 32'hff);
		rd(6'h3f, q);
		chk(q, 32'h0, "unmapped");
		tdone("port four");
		for (k = 0; k < NUM_FUNC; k++) wr(6'(IDX_SETTING_BASE + k), {24'hffffff, 8'(k + 48)});
		wr(6'(IDX_SETTING_BASE + 5), 32'hc5);
		for (k = 0; k < NUM_FUNC; k++) begin
			rd(6'(IDX_SETTING_BASE + k), q);
			chk(q, {24'h0, (k == 5) ? 8'hc5 : 8'(k + 48)}, "setting");
		end
		tdone("settings");
		hold(2990 * TC);
		chk(menuActive, 1'b0, "short set hold");
		hold(3000 * TC + 40);
		chk({menuActive, functionIndex}, {1'b1, FIDX_FIRST}, "menu entry");
		stat(0);
		press(1'b0, 1'b1);
		chk(functionIndex, FIDX_LAST, "down wrap");
		press(1'b1, 1'b0);
		for (k = 1; k <= NUM_FUNC + 1; k++) begin
			press(1'b1, 1'b0);
			stat(k % NUM_FUNC);
		end
		press(1'b1, 1'b1);
		chk(functionIndex, 4'h1, "up and down together");
		hold(1990 * TC);
		chk(menuActive, 1'b1, "short exit hold");
		hold(2000 * TC + 40);
		chk(menuActive, 1'b0, "menu exit");
		press(1'b1, 1'b0);
		chk({menuActive, functionIndex}, {1'b0, 4'h1}, "up in measurement");
		// index left nonzero, so a second entry shows the first function is restored
		hold(3000 * TC + 40);
		chk({menuActive, functionIndex}, {1'b1, FIDX_FIRST}, "menu re-entry");
		tdone("menu");
		results();
	end
endmodule : tb_top
